/* File: tcl_top.sv */
// top: timer channel input routing, output gating, split-half triggers, APB slave
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module tcl_top
	import tcl_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	input  wire logic        serial_receive_line,
	input  wire logic        chan1_timer_input_pin,
	input  wire logic        chan2_timer_input_pin,
	input  wire logic        external_interrupt0_pin,
	input  wire logic [3:0]  channel_interrupt_request,
	input  wire logic        chan1_timer_output,
	input  wire logic        chan3_timer_output,
	input  wire logic [3:0]  channel_clock_select_bit,
	output logic             chan1_timer_input,
	output logic             chan2_timer_input,
	output logic             external_interrupt0,
	output logic             chan1_timer_output_pin,
	output logic             chan3_timer_output_pin,
	output logic [3:0]       channel_enable_status,
	output logic [3:0]       upper_half_enable_status,
	output logic [3:0]       upper_half_start_irq,
	output logic [3:0]       master_of_channel_err
);
	// ***************************************************************
	// registers and decode
	// ***************************************************************
	logic [7:0] timer_io_control_q;
	logic [7:0] input_switch_control_q;
	logic [1:0] split_q;
	logic [3:0] nfen_q;
	logic [3:0] master_q;
	logic [3:0] te_q;
	logic [3:0] teh_q;
	logic       ch1_s1_q;
	logic       ch1_s2_q;
	logic       ch1_s3_q;
	logic       ch2_s1_q;
	logic       ch2_s2_q;
	logic       wr_acc;
	logic [3:0] wr_start;
	logic [3:0] wr_stop;
	logic [3:0] split_mask;
	logic       ch1_raw;

	// word-aligned compare; unmapped addresses answer with pslverr
	function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
		hit = (a[31:2] == off[31:2]);
	endfunction : hit

	function automatic logic mapped(input logic [31:0] a);
		mapped = hit(a, TCL_OFF_IOCTL) | hit(a, TCL_OFF_ISW) | hit(a, TCL_OFF_CHAN) |
			hit(a, TCL_OFF_START) | hit(a, TCL_OFF_STOP) | hit(a, TCL_OFF_STATUS) |
			hit(a, TCL_OFF_NFEN);
	endfunction : mapped

	assign wr_acc     = psel & penable & pwrite & pready;
	assign split_mask = {split_q[1], 1'b0, split_q[0], 1'b0};
	assign wr_start   = (wr_acc & hit(paddr, TCL_OFF_START)) ? pwdata[3:0] : 4'h0;
	assign wr_stop    = (wr_acc & hit(paddr, TCL_OFF_STOP)) ? pwdata[3:0] : 4'h0;

	// single-cycle access phase: pready rises at the edge that ends the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped(paddr);
		end
	end

	// control registers; upper bits dropped so they always read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_io_control_q     <= TCL_RST_IOCTL;
			input_switch_control_q <= TCL_RST_ISW;
			split_q                <= 2'h0;
			nfen_q                 <= 4'h0;
			master_q               <= 4'h0;
		end else if (wr_acc) begin
			if (hit(paddr, TCL_OFF_IOCTL))
				timer_io_control_q <= pwdata[7:0] & TCL_MASK_IOCTL;
			if (hit(paddr, TCL_OFF_ISW))
				input_switch_control_q <= pwdata[7:0] & TCL_MASK_ISW;
			if (hit(paddr, TCL_OFF_CHAN)) begin
				split_q  <= pwdata[1:0];
				master_q <= {1'b0, pwdata[6], 1'b0, pwdata[4]};
			end
			if (hit(paddr, TCL_OFF_NFEN))
				nfen_q <= pwdata[3:0];
		end
	end

	// read mux
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel & ~penable & ~pwrite) begin
			prdata <= 32'h00000000;
			if (hit(paddr, TCL_OFF_IOCTL))
				prdata <= {24'h000000, timer_io_control_q};
			if (hit(paddr, TCL_OFF_ISW))
				prdata <= {24'h000000, input_switch_control_q};
			if (hit(paddr, TCL_OFF_CHAN))
				prdata <= {25'h0, master_q[2], 1'b0, master_q[0], 2'h0, split_q};
			if (hit(paddr, TCL_OFF_STATUS))
				prdata <= {24'h000000, teh_q, te_q};
			if (hit(paddr, TCL_OFF_NFEN))
				prdata <= {28'h0000000, nfen_q};
		end
	end

	// ***************************************************************
	// channel enable: start bits [3:0], upper-half starts [7:4]
	// ***************************************************************
	function automatic logic [3:0] upper_wr(input logic start);
		upper_wr = (wr_acc & hit(paddr, start ? TCL_OFF_START : TCL_OFF_STOP))
			? pwdata[7:4] : 4'h0;
	endfunction : upper_wr

	// linked channels start together because one write carries all bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			te_q  <= 4'h0;
			teh_q <= 4'h0;
		end else begin
			te_q  <= (te_q | wr_start) & ~wr_stop;
			// upper triggers only reach split channels 1/3; stop wins over start
			teh_q <= ((teh_q | (upper_wr(1'b1) & split_mask))
				& ~(upper_wr(1'b0) & split_mask)) & split_mask;
		end
	end

	// upper half raises its own start interrupt on every accepted start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			upper_half_start_irq <= 4'h0;
		else
			upper_half_start_irq <= upper_wr(1'b1) & ~upper_wr(1'b0) & split_mask;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_enable_status    <= 4'h0;
			upper_half_enable_status <= 4'h0;
		end else begin
			channel_enable_status    <= te_q;
			upper_half_enable_status <= teh_q;
		end
	end

	// flag link setups that break grouping: clock mismatch, split+link, master fed by master
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			master_of_channel_err <= 4'h0;
		else begin
			master_of_channel_err[0] <= 1'b0;
			master_of_channel_err[1] <= master_q[0] & (split_q[0] |
				(channel_clock_select_bit[1] != channel_clock_select_bit[0]));
			master_of_channel_err[2] <= master_q[2] & master_q[0] &
				timer_io_control_q[TCL_IO_CLKSEL];
			master_of_channel_err[3] <= master_q[2] & (split_q[1] |
				(channel_clock_select_bit[3] != channel_clock_select_bit[2]));
		end
	end

	// ***************************************************************
	// input routing and noise filter
	// ***************************************************************
	assign ch1_raw = input_switch_control_q[TCL_ISW_CH1] ?
		serial_receive_line : chan1_timer_input_pin;

	// two-stage synchroniser, then a stability stage for the filter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch1_s1_q <= 1'b0;
			ch1_s2_q <= 1'b0;
			ch1_s3_q <= 1'b0;
			ch2_s1_q <= 1'b0;
			ch2_s2_q <= 1'b0;
		end else begin
			ch1_s1_q <= ch1_raw;
			ch1_s2_q <= ch1_s1_q;
			ch1_s3_q <= ch1_s2_q;
			ch2_s1_q <= chan2_timer_input_pin;
			ch2_s2_q <= ch2_s1_q;
		end
	end

	// with nfen_q[1] set, filtered output changes only after two equal samples
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			chan1_timer_input <= 1'b0;
		else if (!nfen_q[1])
			chan1_timer_input <= ch1_s2_q;
		else if (ch1_s2_q == ch1_s3_q)
			chan1_timer_input <= ch1_s3_q;
	end

	// channel 2 source: own pin or channel 1 irq, master signals flow upward only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			chan2_timer_input <= 1'b0;
		else
			chan2_timer_input <= timer_io_control_q[TCL_IO_CLKSEL] ?
				channel_interrupt_request[1] : ch2_s2_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			external_interrupt0 <= 1'b0;
		else
			external_interrupt0 <= input_switch_control_q[TCL_ISW_IRQ0] ?
				serial_receive_line : external_interrupt0_pin;
	end

	// ***************************************************************
	// output gating
	// ***************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan1_timer_output_pin <= 1'b0;
			chan3_timer_output_pin <= 1'b0;
		end else begin
			chan1_timer_output_pin <= chan1_timer_output & ~timer_io_control_q[TCL_IO_GATE1];
			chan3_timer_output_pin <= chan3_timer_output & ~timer_io_control_q[TCL_IO_GATE3];
		end
	end

	// ***************************************************************
	// assertions
	// ***************************************************************
	property p_gate1;
		@(posedge pclk) disable iff (!presetn)
		timer_io_control_q[TCL_IO_GATE1] |=> !chan1_timer_output_pin;
	endproperty
	a_gate1: assert property (p_gate1) else $error("channel 1 output not blocked");

	property p_route1;
		@(posedge pclk) disable iff (!presetn)
		input_switch_control_q[TCL_ISW_CH1] |=> ch1_s1_q == $past(serial_receive_line);
	endproperty
	a_route1: assert property (p_route1) else $error("serial line not routed to ch1");

	property p_irq0;
		@(posedge pclk) disable iff (!presetn)
		!input_switch_control_q[TCL_ISW_IRQ0] |=> external_interrupt0 == $past(external_interrupt0_pin);
	endproperty
	a_irq0: assert property (p_irq0) else $error("irq0 pin path wrong");

	property p_clksel;
		@(posedge pclk) disable iff (!presetn)
		timer_io_control_q[TCL_IO_CLKSEL] |=> chan2_timer_input == $past(channel_interrupt_request[1]);
	endproperty
	a_clksel: assert property (p_clksel) else $error("channel 2 source wrong");

	property p_isw_upper;
		@(posedge pclk) disable iff (!presetn)
		input_switch_control_q[7:2] == 6'h00;
	endproperty
	a_isw_upper: assert property (p_isw_upper) else $error("switch upper bits set");

	property p_nosplit;
		@(posedge pclk) disable iff (!presetn)
		!split_q[0] |=> !teh_q[1];
	endproperty
	a_nosplit: assert property (p_nosplit) else $error("upper half runs in 16-bit mode");

	property p_upstart;
		@(posedge pclk) disable iff (!presetn)
		upper_half_start_irq[1] |-> teh_q[1];
	endproperty
	a_upstart: assert property (p_upstart) else $error("upper start irq without start");

	property p_filter;
		@(posedge pclk) disable iff (!presetn)
		$past(nfen_q[1]) && $changed(chan1_timer_input) |-> $past(ch1_s2_q) == $past(ch1_s3_q);
	endproperty
	a_filter: assert property (p_filter) else $error("filter passed unstable level");

	property p_start;
		@(posedge pclk) disable iff (!presetn)
		wr_start[0] && !wr_stop[0] |=> te_q[0] ##1 channel_enable_status[0];
	endproperty
	a_start: assert property (p_start) else $error("channel 0 did not start");

	c_split_start: cover property (@(posedge pclk) upper_half_start_irq[3]);
	c_serial_ch1:  cover property (@(posedge pclk) input_switch_control_q[TCL_ISW_CH1] && nfen_q[1]);
	c_gate3:       cover property (@(posedge pclk) timer_io_control_q[TCL_IO_GATE3]);
endmodule : tcl_top

/* File: tcl_pkg.sv */
// package: register map, field positions and reset values for timer linking block
package tcl_pkg;
	// ***************************************************************
	// register byte addresses
	// ***************************************************************
	localparam logic [19:0] TCL_ADDR_TIMER_IO_CONTROL   = 20'hF0072;
	localparam logic [19:0] TCL_ADDR_INPUT_SWITCH_CTRL  = 20'hF0073;
	// printed offsets are not word aligned: index, byte address is four times it
	localparam logic [31:0] TCL_OFF_IOCTL   = 32'h003C01C8;
	localparam logic [31:0] TCL_OFF_ISW     = 32'h003C01CC;
	localparam logic [31:0] TCL_OFF_CHAN    = 32'h00000040;
	localparam logic [31:0] TCL_OFF_START   = 32'h00000044;
	localparam logic [31:0] TCL_OFF_STOP    = 32'h00000048;
	localparam logic [31:0] TCL_OFF_STATUS  = 32'h0000004C;
	localparam logic [31:0] TCL_OFF_NFEN    = 32'h00000050;
	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int TCL_ISW_CH1   = 1;
	localparam int TCL_ISW_IRQ0  = 0;
	localparam int TCL_IO_GATE3  = 2;
	localparam int TCL_IO_GATE1  = 1;
	localparam int TCL_IO_CLKSEL = 0;
	localparam int TCL_CH_SPLIT1 = 0;
	localparam int TCL_CH_SPLIT3 = 1;
	// ***************************************************************
	// reset values and field masks
	// ***************************************************************
	localparam logic [7:0] TCL_RST_IOCTL = 8'h00;
	localparam logic [7:0] TCL_RST_ISW   = 8'h00;
	localparam logic [7:0] TCL_MASK_ISW  = 8'h03;
	localparam logic [7:0] TCL_MASK_IOCTL= 8'h07;
	localparam logic [3:0] TCL_CH_ODD    = 4'hA;
	// filter accepts a level held for this many operating-clock cycles
	localparam int unsigned TCL_FILT_CYCLES = 2;
endpackage : tcl_pkg

/* File: tcl_pins_model.sv */
// partner model: external timer pins and serial receive line levels
`timescale 1ns/1ps
// ***************************************************************
// pin drivers seen by the timer linking block
// ***************************************************************
module tcl_pins_model (
	input  wire logic pclk,
	output logic      serial_receive_line,
	output logic      chan1_timer_input_pin,
	output logic      chan2_timer_input_pin,
	output logic      external_interrupt0_pin
);
	logic [3:0] lvl_q;

	// pins are plain driven levels, never left floating
	initial lvl_q = 4'h0;
	// every pin set up as a timer input: driven from outside only
	assign {serial_receive_line, chan1_timer_input_pin} = lvl_q[3:2];
	assign {chan2_timer_input_pin, external_interrupt0_pin} = lvl_q[1:0];

	// order: serial, ch1 pin, ch2 pin, irq0 pin; changed just after an edge
	task automatic set_pins(input logic [3:0] lv);
		@(posedge pclk);
		lvl_q <= lv;
	endtask : set_pins

	// one-cycle pulse: shorter than the filter acceptance window
	task automatic pulse(input logic [3:0] lv);
		logic [3:0] old;
		old = lvl_q;
		@(posedge pclk);
		lvl_q <= lv;
		@(posedge pclk);
		lvl_q <= old;
	endtask : pulse
endmodule : tcl_pins_model

/* File: tcl_top_tb_top.sv */
// testbench: register access, input routing, output gating, split-half triggers
`timescale 1ns/1ps
module tcl_top_tb_top
	import tcl_pkg::*;
;
	// ***************************************************************
	// signals
	// ***************************************************************
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic        ser, c1p, c2p, i0p, c1o, c3o, c1i, c2i, ext0, c1pin, c3pin, seen;
	logic [3:0]  irq_req, cks, en_st, up_st, up_irq, m_err, irq_seen;
	int          miscompares, num_checks;

	// ***************************************************************
	// clock, instances, monitors
	// ***************************************************************
	initial pclk = 1'b0;
	always #25 pclk = ~pclk;

	tcl_pins_model pins (.pclk(pclk), .serial_receive_line(ser), .chan1_timer_input_pin(c1p),
		.chan2_timer_input_pin(c2p), .external_interrupt0_pin(i0p));

	tcl_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .serial_receive_line(ser), .chan1_timer_input_pin(c1p),
		.chan2_timer_input_pin(c2p), .external_interrupt0_pin(i0p),
		.channel_interrupt_request(irq_req), .chan1_timer_output(c1o),
		.chan3_timer_output(c3o), .channel_clock_select_bit(cks),
		.chan1_timer_input(c1i), .chan2_timer_input(c2i), .external_interrupt0(ext0),
		.chan1_timer_output_pin(c1pin), .chan3_timer_output_pin(c3pin),
		.channel_enable_status(en_st), .upper_half_enable_status(up_st),
		.upper_half_start_irq(up_irq), .master_of_channel_err(m_err));

	// short pulses are caught mid-cycle, away from the launching edge
	always @(negedge pclk) begin
		if (c1i === 1'b1) seen <= 1'b1;
		irq_seen <= irq_seen | up_irq;
	end

	// ***************************************************************
	// tasks
	// ***************************************************************
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// setup, then access held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// pready, prdata and pslverr are taken at the rising edge itself
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			miscompares++;
			close_out();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0);
		chk({31'h0, er}, {31'h0, e});
		if (e === 1'b0) begin
			chk(rd, exp);
		end
	endtask : rdchk

	// covers two sync stages, two filter samples and the output register
	task automatic settle();
		repeat (6) @(posedge pclk);
		@(negedge pclk);
	endtask : settle

	// ***************************************************************
	// watchdog and main sequence
	// ***************************************************************
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		close_out();
	end

	initial begin
		{presetn, psel, penable, pwrite, c1o, c3o, seen} = 7'h0;
		{paddr, pwdata, irq_req, cks, irq_seen} = 76'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(TCL_OFF_IOCTL, {24'h0, TCL_RST_IOCTL}, 1'b0);
		rdchk(TCL_OFF_ISW, {24'h0, TCL_RST_ISW}, 1'b0);
		wr(TCL_OFF_ISW, 32'h03);
		rdchk(TCL_OFF_ISW, {24'h0, TCL_MASK_ISW}, 1'b0);
		wr(TCL_OFF_IOCTL, 32'hFF);
		rdchk(TCL_OFF_IOCTL, {24'h0, TCL_MASK_IOCTL}, 1'b0);
		rdchk(32'h00000100, 32'h0, 1'b1);
		wr(TCL_OFF_IOCTL, 32'h0);
		// every switch setting against both source polarities
		for (int i = 0; i < 8; i++) begin
			wr(TCL_OFF_ISW, {30'h0, i[1:0]});
			pins.set_pins(i[2] ? 4'b1000 : 4'b0101);
			settle();
			chk({31'h0, c1i}, {31'h0, i[1] ~^ i[2]});
			chk({31'h0, ext0}, {31'h0, i[0] ~^ i[2]});
		end
		// channel 2 source: pin, then channel 1 request
		pins.set_pins(4'b0010);
		settle();
		chk({31'h0, c2i}, 32'h1);
		wr(TCL_OFF_IOCTL, 32'h1);
		settle();
		chk({31'h0, c2i}, 32'h0);
		@(posedge pclk);
		irq_req <= 4'b0010;
		settle();
		chk({31'h0, c2i}, 32'h1);
		@(posedge pclk);
		irq_req <= 4'b0000;
		c1o <= 1'b1;
		c3o <= 1'b1;
		for (int g = 0; g < 4; g++) begin
			wr(TCL_OFF_IOCTL, {29'h0, g[1:0], 1'b0});
			settle();
			chk({30'h0, c3pin, c1pin}, {30'h0, ~g[1], ~g[0]});
		end
		// filter follows the switched source and rejects one-cycle pulses
		wr(TCL_OFF_ISW, 32'h2);
		wr(TCL_OFF_NFEN, 32'h2);
		pins.set_pins(4'b0000);
		settle();
		seen = 1'b0;
		pins.pulse(4'b1000);
		settle();
		chk({31'h0, seen}, 32'h0);
		pins.set_pins(4'b1000);
		settle();
		chk({31'h0, c1i}, 32'h1);
		pins.set_pins(4'b0000);
		settle();
		wr(TCL_OFF_NFEN, 32'h0);
		seen = 1'b0;
		pins.pulse(4'b1000);
		settle();
		chk({31'h0, seen}, 32'h1);
		wr(TCL_OFF_ISW, 32'h0);
		seen = 1'b0;
		pins.pulse(4'b1000);
		settle();
		chk({31'h0, seen}, 32'h0);
		// 16-bit mode: upper triggers ignored, no link error on matching clocks
		wr(TCL_OFF_CHAN, 32'h50);
		wr(TCL_OFF_START, 32'hF0);
		settle();
		chk({28'h0, up_st}, 32'h0);
		chk({28'h0, irq_seen}, 32'h0);
		chk({28'h0, m_err}, 32'h0);
		// slave 1 on a different operating clock than master 0 is flagged
		@(posedge pclk);
		cks <= 4'b0010;
		settle();
		chk({28'h0, m_err}, 32'h2);
		@(posedge pclk);
		cks <= 4'b0000;
		wr(TCL_OFF_START, 32'h0F);
		settle();
		chk({28'h0, en_st}, 32'hF);
		// retrigger only the master start bits while counting
		wr(TCL_OFF_START, 32'h05);
		settle();
		chk({28'h0, en_st}, 32'hF);
		rdchk(TCL_OFF_STATUS, 32'h0F, 1'b0);
		wr(TCL_OFF_STOP, 32'h0F);
		settle();
		chk({28'h0, en_st}, 32'h0);
		// split mode: only channels 1 and 3 get an upper half
		wr(TCL_OFF_CHAN, 32'h3);
		irq_seen = 4'h0;
		wr(TCL_OFF_START, 32'hF0);
		settle();
		chk({28'h0, up_st}, 32'hA);
		chk({28'h0, irq_seen}, 32'hA);
		chk({28'h0, en_st}, 32'h0);
		wr(TCL_OFF_STOP, 32'h20);
		settle();
		chk({28'h0, up_st}, 32'h8);
		close_out();
	end
endmodule : tcl_top_tb_top
